// ===== src/ccsic_regs.svh
// named constants of the controller core: reset values, stack limits,
// status bit positions, pending bit positions and interrupt vectors.
// assumes a 12-bit unified map, data segment low and code segment high.
`ifndef CCSIC_REGS_SVH
`define CCSIC_REGS_SVH

// fetch address after reset, also the base of the code segment
`define CCSIC_PC_RESET 12'h800
`define CCSIC_SP_RESET 8'h3F
// upper nibble of every legal stack pointer value
`define CCSIC_SP_BASE 4'h3
`define CCSIC_SP_STEP 8'h02
`define CCSIC_SP_BYTE 8'h01
`define CCSIC_DATA_PAGE 4'h0
`define CCSIC_ADDR_ONE 12'h001

// status register bit positions
`define CCSIC_SR_C 0
`define CCSIC_SR_H 1
`define CCSIC_SR_Z 2
`define CCSIC_SR_N 3
`define CCSIC_SR_G 4
`define CCSIC_SR_R 5

// pending bit positions
`define CCSIC_PEND_WAKE 2
`define CCSIC_PEND_T0 1
`define CCSIC_PEND_T1 0

// vector table entries in code space, two bytes each, high byte first
`define CCSIC_VEC_WAKE 12'hFF8
`define CCSIC_VEC_T0 12'hFFA
`define CCSIC_VEC_T1 12'hFFC
`define CCSIC_VEC_SOFT 12'hFFE

`endif

// ===== src/ccsic_pkg.sv
// types shared by the controller core and its flag unit.
// assumes ccsic_regs.svh for every numeric constant.
`default_nettype none

package ccsic_pkg;

  typedef enum logic [3:0] {
    ALU_ADC, ALU_ADD, ALU_SUBC, ALU_AND, ALU_OR, ALU_XOR,
    ALU_RLC, ALU_RRC, ALU_INC, ALU_DEC, ALU_CLR, ALU_PASS
  } ccsic_alu_t;

  typedef enum logic [3:0] {
    OP_ALU, OP_LDX, OP_LDSP, OP_LDC, OP_INVERT_FLAG_BIT, OP_SETG,
    OP_CALL, OP_JMP, OP_JREL, OP_RET, OP_RETURN_FROM_IRQ, OP_SWI
  } ccsic_op_t;

  typedef enum logic [1:0] {
    MODE_IMM, MODE_DIRECT, MODE_INDIRECT, MODE_INDEXED
  } ccsic_mode_t;

  typedef enum logic [1:0] {
    SRC_WAKE, SRC_T0, SRC_T1, SRC_SOFT
  } ccsic_src_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_OPER, ST_PUSH_HI, ST_VEC_A, ST_VEC_B, ST_VEC_C,
    ST_PULL_HI, ST_PULL_LO
  } ccsic_st_t;

  // one decoded instruction handed to the core
  typedef struct packed {
    ccsic_op_t op;
    ccsic_alu_t alu;
    ccsic_mode_t mode;
    logic [7:0] imm8;
    logic [11:0] addr;
    logic [2:0] bit_sel;
    logic [1:0] len;
  } ccsic_req_t;

  // data memory port, read data valid in the same cycle as re
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } ccsic_dm_t;

endpackage

`default_nettype wire

// ===== src/ccsic_alu.sv
// arithmetic and logic unit with flag results and flag update enables.
// purely combinational; the core registers whatever it keeps.
`default_nettype none
`include "ccsic_regs.svh"

module ccsic_alu
  import ccsic_pkg::*;
(
  input wire ccsic_alu_t alu_op,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic cin,
  output logic [7:0] res,
  output logic cout,
  output logic hout,
  output logic zout,
  output logic nout,
  output logic upd_c,
  output logic upd_h,
  output logic upd_zn
);

  logic [8:0] wide;
  logic [4:0] half;

  always_comb begin
    wide = 9'h000;
    half = 5'h00;
    upd_c = 1'b0;
    upd_h = 1'b0;
    upd_zn = 1'b1;
    unique case (alu_op)
      ALU_ADC: begin
        half = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        wide = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        upd_c = 1'b1;
        upd_h = 1'b1;
      end
      ALU_ADD: wide = {1'b0, a} + {1'b0, b};
      ALU_SUBC: begin
        // carry in and carry out both mean borrow here
        half = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
        wide = {1'b0, a} - {1'b0, b} - {8'h00, cin};
        upd_c = 1'b1;
        upd_h = 1'b1;
      end
      ALU_AND: wide = {1'b0, a & b};
      ALU_OR: wide = {1'b0, a | b};
      ALU_XOR: wide = {1'b0, a ^ b};
      ALU_RLC: begin
        wide = {a, cin};
        upd_c = 1'b1;
      end
      ALU_RRC: begin
        wide = {a[0], cin, a[7:1]};
        upd_c = 1'b1;
      end
      ALU_INC: wide = {1'b0, a} + 9'h001;
      ALU_DEC: wide = {1'b0, a} - 9'h001;
      ALU_CLR: begin
        wide = 9'h000;
        upd_c = 1'b1;
      end
      ALU_PASS: begin
        wide = {1'b0, b};
        upd_zn = 1'b0;
      end
    endcase
    res = wide[7:0];
    cout = wide[8];
    hout = half[4];
    zout = (wide[7:0] == 8'h00);
    nout = wide[7];
  end

endmodule

`default_nettype wire

// ===== src/ccsic_core.sv
// control part of the 8-bit controller core: registers, stack,
// interrupt entry and return, addressing and program flow.
// assumes a decoder that presents one instruction at a time and a
// data memory whose read data is valid in the same cycle as the read strobe.
//
// Behaviour
// - pc 11 bits, fetch starts at 0x800
// - index pointer 12 bits, base or storage
// - stack pointer loaded within 0x30-0x3F, resets 0x3F
// - push subtracts two, pull adds two
// - call pushes next address, low byte first
// - return pulls address back into pc
// - carry from add and subtract with carry, rotates, clear, load, invert
// - half carry across accumulator nibbles
// - zero flag when result is zero
// - negative flag copies result msb
// - mask cleared by reset, set by software
// - masked requests still latch as pending
// - entry after instruction, five cycles, vector
// - mask cleared after stacking and vector fetch, except for software
// - interrupt return pulls address, sets mask
// - four sources, software one never masked
// - fixed priority wakeup, first_timer_irq, second_timer_irq, software
// - indexed adds unsigned offset to pointer
// - indirect reads memory at pointer
// - direct uses 8-bit data address
// - immediate uses instruction byte as operand
// - absolute branch replaces all pc bits
// - relative branch adds displacement to next pc
`default_nettype none
`include "ccsic_regs.svh"

module ccsic_core
  import ccsic_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic op_valid,
  input wire ccsic_req_t op_req,
  output logic op_ready,
  input wire logic multi_input_wakeup,
  input wire logic first_timer_irq,
  input wire logic second_timer_irq,
  input wire logic eeprom_write_busy,
  output ccsic_dm_t dm_bus,
  input wire logic [7:0] dm_rdata,
  output logic [11:0] fetch_addr,
  output logic [7:0] acc_out,
  output logic [11:0] x_out,
  output logic [7:0] sp_out,
  output logic [7:0] core_status_flags,
  output logic [2:0] irq_taken
);

  ////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    ccsic_st_t st;
    ccsic_req_t req;
    ccsic_src_t src;
    logic irq_path;
    logic [7:0] acc;
    logic [11:0] x;
    logic [10:0] pc;
    logic [7:0] sp;
    logic [7:0] sr;
    logic [2:0] pend;
    logic [7:0] hold;
    ccsic_dm_t dm;
    logic ready;
    logic [2:0] ack;
    logic [11:0] fetch;
  } ccsic_state_t;

  localparam logic [11:0] CODE_BASE = `CCSIC_PC_RESET;

  ccsic_state_t q;
  ccsic_state_t s;

  logic take_op;
  logic irq_go;
  logic exec;
  ccsic_req_t exec_req;
  logic [7:0] operand;
  logic [11:0] ea;
  logic [10:0] pc_inc;
  logic [10:0] rel_target;
  logic [2:0] req_now;
  logic [2:0] pend_clr;
  logic [2:0] pend_sel;
  ccsic_src_t pick;
  logic [11:0] vec_addr;
  logic [7:0] sp_dec;
  logic [7:0] sp_pull_hi;
  logic [7:0] sp_pull_lo;

  logic [7:0] alu_res;
  logic alu_c;
  logic alu_h;
  logic alu_z;
  logic alu_n;
  logic upd_c;
  logic upd_h;
  logic upd_zn;

  ////////////////////////////////////////////////////////////////////////
  // arbitration and address formation

  assign req_now = {multi_input_wakeup, first_timer_irq, second_timer_irq};

  // only the three masked sources sit in pend; software comes as an op
  always_comb begin
    irq_go = 1'b0;
    pick = SRC_T1;
    pend_sel = 3'b000;
    if (q.st == ST_IDLE && q.sr[`CCSIC_SR_G]) begin
      if (q.pend[`CCSIC_PEND_WAKE]) begin
        irq_go = 1'b1;
        pick = SRC_WAKE;
        pend_sel[`CCSIC_PEND_WAKE] = 1'b1;
      end else if (q.pend[`CCSIC_PEND_T0]) begin
        irq_go = 1'b1;
        pick = SRC_T0;
        pend_sel[`CCSIC_PEND_T0] = 1'b1;
      end else if (q.pend[`CCSIC_PEND_T1]) begin
        irq_go = 1'b1;
        pick = SRC_T1;
        pend_sel[`CCSIC_PEND_T1] = 1'b1;
      end
    end
  end

  // a waiting software interrupt loses to any enabled pending source
  assign take_op = op_valid && q.ready && !irq_go;

  always_comb begin
    unique case (op_req.mode)
      MODE_IMM: ea = q.x;
      MODE_DIRECT: ea = {`CCSIC_DATA_PAGE, op_req.imm8};
      MODE_INDIRECT: ea = q.x;
      MODE_INDEXED: ea = q.x + {4'h0, op_req.imm8};
    endcase
  end

  always_comb begin
    unique case (q.src)
      SRC_WAKE: vec_addr = `CCSIC_VEC_WAKE;
      SRC_T0: vec_addr = `CCSIC_VEC_T0;
      SRC_T1: vec_addr = `CCSIC_VEC_T1;
      SRC_SOFT: vec_addr = `CCSIC_VEC_SOFT;
    endcase
  end

  assign pc_inc = q.pc + {9'h000, op_req.len};
  assign rel_target = pc_inc + {{3{op_req.imm8[7]}}, op_req.imm8};
  assign sp_dec = q.sp - `CCSIC_SP_BYTE;
  assign sp_pull_hi = q.sp + `CCSIC_SP_BYTE;
  assign sp_pull_lo = q.sp + `CCSIC_SP_STEP;

  // immediate ops run at once, memory ops one cycle later with read data
  assign exec = (take_op && op_req.mode == MODE_IMM) || q.st == ST_OPER;
  assign exec_req = (q.st == ST_OPER) ? q.req : op_req;
  assign operand = (q.st == ST_OPER) ? dm_rdata : op_req.imm8;

  ccsic_alu u_alu (
    .alu_op(exec_req.alu),
    .a(q.acc),
    .b(operand),
    .cin(q.sr[`CCSIC_SR_C]),
    .res(alu_res),
    .cout(alu_c),
    .hout(alu_h),
    .zout(alu_z),
    .nout(alu_n),
    .upd_c(upd_c),
    .upd_h(upd_h),
    .upd_zn(upd_zn)
  );

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s = q;
    pend_clr = 3'b000;
    s.dm.we = 1'b0;
    s.dm.re = 1'b0;
    s.ack = 3'b000;
    s.sr[`CCSIC_SR_R] = eeprom_write_busy;
    unique case (q.st)
      ST_IDLE: begin
        if (irq_go) begin
          // current instruction is already done, so entry starts here
          pend_clr = pend_sel;
          s.ack = pend_sel;
          s.src = pick;
          s.irq_path = 1'b1;
          s.dm.addr = {`CCSIC_DATA_PAGE, q.sp};
          s.dm.wdata = q.pc[7:0];
          s.dm.we = 1'b1;
          s.hold = {5'h00, q.pc[10:8]};
          s.st = ST_PUSH_HI;
        end else if (take_op) begin
          s.req = op_req;
          s.pc = pc_inc;
          unique case (op_req.op)
            OP_ALU, OP_LDC: begin
              if (op_req.mode != MODE_IMM) begin
                s.dm.addr = ea;
                s.dm.re = 1'b1;
                s.st = ST_OPER;
              end
            end
            OP_LDX: s.x = op_req.addr;
            OP_LDSP: s.sp = {`CCSIC_SP_BASE, op_req.imm8[3:0]};
            OP_INVERT_FLAG_BIT: s.sr[`CCSIC_SR_C] = ~q.sr[`CCSIC_SR_C];
            OP_SETG: s.sr[`CCSIC_SR_G] = 1'b1;
            OP_CALL: begin
              s.dm.addr = {`CCSIC_DATA_PAGE, q.sp};
              s.dm.wdata = pc_inc[7:0];
              s.dm.we = 1'b1;
              s.hold = {5'h00, pc_inc[10:8]};
              s.pc = op_req.addr[10:0];
              s.irq_path = 1'b0;
              s.st = ST_PUSH_HI;
            end
            OP_JMP: s.pc = op_req.addr[10:0];
            OP_JREL: s.pc = rel_target;
            OP_RET, OP_RETURN_FROM_IRQ: begin
              s.dm.addr = {`CCSIC_DATA_PAGE, sp_pull_hi};
              s.dm.re = 1'b1;
              s.st = ST_PULL_HI;
            end
            OP_SWI: begin
              // never gated and leaves the mask alone
              s.src = SRC_SOFT;
              s.irq_path = 1'b1;
              s.dm.addr = {`CCSIC_DATA_PAGE, q.sp};
              s.dm.wdata = pc_inc[7:0];
              s.dm.we = 1'b1;
              s.hold = {5'h00, pc_inc[10:8]};
              s.st = ST_PUSH_HI;
            end
          endcase
        end
      end
      ST_OPER: s.st = ST_IDLE;
      ST_PUSH_HI: begin
        s.dm.addr = {`CCSIC_DATA_PAGE, sp_dec};
        s.dm.wdata = q.hold;
        s.dm.we = 1'b1;
        s.sp = q.sp - `CCSIC_SP_STEP;
        s.st = q.irq_path ? ST_VEC_A : ST_IDLE;
      end
      ST_VEC_A: begin
        s.dm.addr = vec_addr;
        s.dm.re = 1'b1;
        s.st = ST_VEC_B;
      end
      ST_VEC_B: begin
        s.hold = dm_rdata;
        s.dm.addr = vec_addr + `CCSIC_ADDR_ONE;
        s.dm.re = 1'b1;
        s.st = ST_VEC_C;
      end
      ST_VEC_C: begin
        s.pc = {q.hold[2:0], dm_rdata};
        if (q.src != SRC_SOFT) begin
          s.sr[`CCSIC_SR_G] = 1'b0;
        end
        s.irq_path = 1'b0;
        s.st = ST_IDLE;
      end
      ST_PULL_HI: begin
        s.hold = dm_rdata;
        s.dm.addr = {`CCSIC_DATA_PAGE, sp_pull_lo};
        s.dm.re = 1'b1;
        s.st = ST_PULL_LO;
      end
      ST_PULL_LO: begin
        s.pc = {q.hold[2:0], dm_rdata};
        s.sp = sp_pull_lo;
        if (q.req.op == OP_RETURN_FROM_IRQ) begin
          s.sr[`CCSIC_SR_G] = 1'b1;
        end
        s.st = ST_IDLE;
      end
    endcase

    if (exec && exec_req.op == OP_ALU) begin
      s.acc = alu_res;
      if (upd_c) begin
        s.sr[`CCSIC_SR_C] = alu_c;
      end
      if (upd_h) begin
        s.sr[`CCSIC_SR_H] = alu_h;
      end
      if (upd_zn) begin
        s.sr[`CCSIC_SR_Z] = alu_z;
        s.sr[`CCSIC_SR_N] = alu_n;
      end
    end
    if (exec && exec_req.op == OP_LDC) begin
      s.sr[`CCSIC_SR_C] = operand[exec_req.bit_sel];
    end

    // latch regardless of the mask; a new request beats the clear
    s.pend = (q.pend & ~pend_clr) | req_now;

    s.ready = (s.st == ST_IDLE) && !(s.sr[`CCSIC_SR_G] && (|s.pend));
    s.fetch = CODE_BASE | {1'b0, s.pc};
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      q <= '0;
      q.pc <= CODE_BASE[10:0];
      q.fetch <= CODE_BASE;
      q.sp <= `CCSIC_SP_RESET;
    end else begin
      q <= s;
    end
  end

  assign op_ready = q.ready;
  assign dm_bus = q.dm;
  assign fetch_addr = q.fetch;
  assign acc_out = q.acc;
  assign x_out = q.x;
  assign sp_out = q.sp;
  assign core_status_flags = q.sr;
  assign irq_taken = q.ack;

endmodule

`default_nettype wire

// ===== test/ccsic_core_assertions.sv
// concurrent checks on the controller core ports.
// assumes one clock and a synchronous active-high reset.
`default_nettype none

module ccsic_core_chk
  import ccsic_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic op_valid,
  input wire ccsic_req_t op_req,
  input wire logic op_ready,
  input wire ccsic_dm_t dm_bus,
  input wire logic [11:0] fetch_addr,
  input wire logic [7:0] acc_out,
  input wire logic [7:0] sp_out,
  input wire logic [7:0] core_status_flags,
  input wire logic [2:0] irq_taken
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic tk;
  logic g;
  assign tk = op_valid && op_ready;
  assign g = core_status_flags[4];
  ////////////////////////////////////////
  chk_reset_state: assert property (
    $past(reset) |-> fetch_addr == 12'h800 && sp_out == 8'h3F && !g)
    else $error("state after reset wrong");
  chk_sp_load: assert property (
    tk && op_req.op == OP_LDSP |=> sp_out == {4'h3, $past(op_req.imm8[3:0])})
    else $error("stack pointer load wrong");
  chk_call_push: assert property (
    tk && op_req.op == OP_CALL |=> dm_bus.we && dm_bus.addr == {4'h0, $past(sp_out)}
    && dm_bus.wdata == $past(fetch_addr[7:0] + op_req.len)
    ##1 dm_bus.we && sp_out == $past(sp_out, 2) - 8'h02)
    else $error("call push wrong");
  chk_abs_target: assert property (
    tk && op_req.op inside {OP_CALL, OP_JMP}
    |=> fetch_addr == {1'b1, $past(op_req.addr[10:0])})
    else $error("absolute target wrong");
  chk_ret_pull: assert property (
    tk && op_req.op inside {OP_RET, OP_RETURN_FROM_IRQ}
    |=> dm_bus.re && dm_bus.addr == {4'h0, $past(sp_out) + 8'h01}
    ##2 sp_out == $past(sp_out, 3) + 8'h02)
    else $error("return pull wrong");
  chk_return_from_irq_mask: assert property (
    tk && op_req.op == OP_RETURN_FROM_IRQ |-> ##3 g)
    else $error("mask not set on return");
  chk_irq_gated: assert property (
    irq_taken != 3'h0 |-> $past(g))
    else $error("irq taken while masked");
  chk_mask_clear: assert property (
    irq_taken != 3'h0 |-> g [*4] ##1 !g)
    else $error("mask cleared at wrong time");
  chk_wake_vec: assert property (
    irq_taken[2] |-> ##2 dm_bus.re && dm_bus.addr == 12'hFF8)
    else $error("wakeup vector wrong");
  chk_zn_flags: assert property (
    tk && op_req.op == OP_ALU && op_req.alu inside {ALU_AND, ALU_OR, ALU_XOR}
    && op_req.mode == MODE_IMM
    |=> core_status_flags[2] == (acc_out == 8'h00) && core_status_flags[3] == acc_out[7])
    else $error("zero or negative flag wrong");
  chk_load_imm: assert property (
    tk && op_req.op == OP_ALU && op_req.alu == ALU_PASS && op_req.mode == MODE_IMM
    |=> acc_out == $past(op_req.imm8))
    else $error("immediate load wrong");
  cover property (tk && op_req.op == OP_CALL);
  cover property (irq_taken[2]);
  cover property (irq_taken[1]);
  cover property (tk && op_req.op == OP_SWI);
endmodule

bind ccsic_core ccsic_core_chk u_ccsic_core_chk (.sys_clk, .reset, .op_valid, .op_req,
  .op_ready, .dm_bus, .fetch_addr, .acc_out, .sp_out, .core_status_flags, .irq_taken);

`default_nettype wire

// ===== test/ccsic_dmem_model.sv
// data memory facing the core's data port.
// assumes one strobe per cycle; read data stands while the strobe does.
`default_nettype none

module ccsic_dmem_model
  import ccsic_pkg::*;
(
  input wire logic sys_clk,
  input wire ccsic_dm_t dm_bus,
  output logic [7:0] dm_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:4095];
  // the core samples read data in the cycle its registered strobe stands
  always @(posedge sys_clk) begin
    if (dm_bus.we) mem[dm_bus.addr] <= dm_bus.wdata;
  end
  // outside a read the data is inverted, so a misplaced sample never matches
  assign dm_rdata = dm_bus.re ? mem[dm_bus.addr] : ~mem[dm_bus.addr];
endmodule

`default_nettype wire

// ===== test/ccsic_core_tb_top.sv
// directed bench for the controller core with a data memory model.
// assumes the core takes one instruction per op_valid/op_ready pair.
`default_nettype none

module ccsic_core_tb_top
  import ccsic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic op_valid = 1'b0;
  ccsic_req_t op_req = '0;
  logic op_ready;
  logic [2:0] irq = 3'h0;
  logic busy = 1'b0;
  ccsic_dm_t dm_bus;
  logic [7:0] dm_rdata;
  logic [11:0] fetch_addr;
  logic [7:0] acc_out;
  logic [11:0] x_out;
  logic [7:0] sp_out;
  logic [7:0] core_status_flags;
  logic [2:0] irq_taken;
  logic [2:0] seen = 3'h0;
  int fails = 0;
  int check_count = 0;

  always #10 sys_clk = ~sys_clk;
  // the entry pulse is one cycle; keep it for later inspection
  always @(posedge sys_clk) if (irq_taken !== 3'h0) seen <= irq_taken;

  ccsic_core u_ccsic_core (.sys_clk(sys_clk), .reset(reset), .op_valid(op_valid),
    .op_req(op_req), .op_ready(op_ready), .multi_input_wakeup(irq[2]),
    .first_timer_irq(irq[1]), .second_timer_irq(irq[0]), .eeprom_write_busy(busy),
    .dm_bus(dm_bus), .dm_rdata(dm_rdata), .fetch_addr(fetch_addr), .acc_out(acc_out),
    .x_out(x_out), .sp_out(sp_out), .core_status_flags(core_status_flags),
    .irq_taken(irq_taken));
  ccsic_dmem_model u_ccsic_dmem_model (.sys_clk(sys_clk), .dm_bus(dm_bus),
    .dm_rdata(dm_rdata));

  ////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    cmp({4'h0, got}, {4'h0, exp});
  endtask

  task automatic settle();
    int n;
    n = 0;
    repeat (3) @(posedge sys_clk);
    while (op_ready !== 1'b1) begin
      if (n++ > 30) begin fails++; results(); end
      @(posedge sys_clk);
    end
    #1;
  endtask

  task automatic issue(input ccsic_op_t op, input ccsic_alu_t alu, input ccsic_mode_t md,
    input logic [7:0] i8, input logic [11:0] ad, input logic [1:0] ln);
    int n;
    n = 0;
    @(posedge sys_clk);
    op_valid <= 1'b1;
    op_req <= {op, alu, md, i8, ad, 3'h0, ln};
    do begin
      @(posedge sys_clk);
      if (n++ > 30) begin fails++; results(); end
    end while (op_ready !== 1'b1);
    op_valid <= 1'b0;
    settle();
  endtask

  ////////////////////////////////////////
  initial begin
    int n;
    u_ccsic_dmem_model.mem[12'h042] = 8'h5A;
    u_ccsic_dmem_model.mem[12'h043] = 8'h01;
    u_ccsic_dmem_model.mem[12'h123] = 8'hC3;
    u_ccsic_dmem_model.mem[12'h213] = 8'h3C;
    {u_ccsic_dmem_model.mem[12'hFF8], u_ccsic_dmem_model.mem[12'hFF9]} = 16'h0220;
    {u_ccsic_dmem_model.mem[12'hFFA], u_ccsic_dmem_model.mem[12'hFFB]} = 16'h0330;
    {u_ccsic_dmem_model.mem[12'hFFC], u_ccsic_dmem_model.mem[12'hFFD]} = 16'h0440;
    {u_ccsic_dmem_model.mem[12'hFFE], u_ccsic_dmem_model.mem[12'hFFF]} = 16'h0110;
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    busy <= 1'b1;
    #1;
    cmp(fetch_addr, 12'h800);
    cmp8(sp_out, 8'h3F);
    cmp8(core_status_flags & 8'h1F, 8'h00);
    issue(OP_LDSP, ALU_PASS, MODE_IMM, 8'h27, 12'h000, 2'd1);
    cmp8(sp_out, 8'h37);
    issue(OP_LDX, ALU_PASS, MODE_IMM, 8'h00, 12'h123, 2'd3);
    cmp(x_out, 12'h123);
    issue(OP_ALU, ALU_PASS, MODE_IMM, 8'h81, 12'h000, 2'd2);
    issue(OP_ALU, ALU_ADC, MODE_IMM, 8'h7F, 12'h000, 2'd2);
    cmp8(core_status_flags & 8'h0F, 8'h07);
    issue(OP_ALU, ALU_OR, MODE_IMM, 8'h90, 12'h000, 2'd2);
    cmp8(core_status_flags & 8'h0C, 8'h08);
    issue(OP_INVERT_FLAG_BIT, ALU_PASS, MODE_IMM, 8'h00, 12'h000, 2'd1);
    cmp8(core_status_flags & 8'h01, 8'h00);
    issue(OP_ALU, ALU_SUBC, MODE_IMM, 8'h10, 12'h000, 2'd2);
    cmp8(core_status_flags & 8'h0F, 8'h08);
    issue(OP_ALU, ALU_RLC, MODE_IMM, 8'h00, 12'h000, 2'd1);
    cmp8({acc_out[3:0], core_status_flags[3:0]}, 8'h05);
    issue(OP_ALU, ALU_RRC, MODE_IMM, 8'h00, 12'h000, 2'd1);
    cmp8(acc_out, 8'h80);
    cmp8(core_status_flags & 8'h0F, 8'h08);
    issue(OP_LDC, ALU_PASS, MODE_DIRECT, 8'h43, 12'h000, 2'd2);
    cmp8(core_status_flags & 8'h01, 8'h01);
    issue(OP_ALU, ALU_PASS, MODE_DIRECT, 8'h42, 12'h000, 2'd2);
    cmp8(acc_out, 8'h5A);
    issue(OP_ALU, ALU_PASS, MODE_INDIRECT, 8'h00, 12'h000, 2'd1);
    cmp8(acc_out, 8'hC3);
    issue(OP_ALU, ALU_PASS, MODE_INDEXED, 8'hF0, 12'h000, 2'd2);
    cmp8(acc_out, 8'h3C);
    issue(OP_JMP, ALU_PASS, MODE_IMM, 8'h00, 12'h456, 2'd3);
    cmp(fetch_addr, 12'hC56);
    issue(OP_JREL, ALU_PASS, MODE_IMM, 8'hF0, 12'h000, 2'd2);
    cmp(fetch_addr, 12'hC48);
    issue(OP_CALL, ALU_PASS, MODE_IMM, 8'h00, 12'h100, 2'd3);
    cmp(fetch_addr, 12'h900);
    cmp8(u_ccsic_dmem_model.mem[12'h037], 8'h4B);
    cmp8(u_ccsic_dmem_model.mem[12'h036], 8'h04);
    cmp8(sp_out, 8'h35);
    issue(OP_RET, ALU_PASS, MODE_IMM, 8'h00, 12'h000, 2'd1);
    cmp(fetch_addr, 12'hC4B);
    cmp8(sp_out, 8'h37);
    @(posedge sys_clk) irq <= 3'b111;
    @(posedge sys_clk) irq <= 3'b000;
    // mask still clear: requests wait while work goes on
    issue(OP_ALU, ALU_PASS, MODE_IMM, 8'h11, 12'h000, 2'd2);
    cmp8(acc_out, 8'h11);
    issue(OP_SETG, ALU_PASS, MODE_IMM, 8'h00, 12'h000, 2'd1);
    cmp({9'h0, seen}, 12'h004);
    cmp(fetch_addr, 12'hA20);
    cmp8(u_ccsic_dmem_model.mem[12'h037], 8'h4E);
    cmp8(core_status_flags & 8'h10, 8'h00);
    issue(OP_RETURN_FROM_IRQ, ALU_PASS, MODE_IMM, 8'h00, 12'h000, 2'd1);
    n = 0;
    while (seen !== 3'b010) begin
      if (n++ > 30) begin fails++; results(); end
      @(posedge sys_clk);
    end
    settle();
    cmp(fetch_addr, 12'hB30);
    cmp8(sp_out, 8'h35);
    issue(OP_SWI, ALU_PASS, MODE_IMM, 8'h00, 12'h000, 2'd1);
    cmp(fetch_addr, 12'h910);
    cmp8(core_status_flags & 8'h10, 8'h00);
    issue(OP_RET, ALU_PASS, MODE_IMM, 8'h00, 12'h000, 2'd1);
    cmp(fetch_addr, 12'hB31);
    cmp8(sp_out, 8'h35);
    // second_timer_irq has waited since the burst; unmasking lets it in last
    issue(OP_SETG, ALU_PASS, MODE_IMM, 8'h00, 12'h000, 2'd1);
    cmp({9'h0, seen}, 12'h001);
    cmp(fetch_addr, 12'hC40);
    cmp8(u_ccsic_dmem_model.mem[12'h035], 8'h32);
    cmp8(sp_out, 8'h33);
    cmp8(core_status_flags & 8'h20, 8'h20);
    results();
  end
endmodule

`default_nettype wire
